/* File: verilog/hvpdo_pkg.sv */
// Purpose: Shared constants for the high-voltage pin driver override bank.
// Assumes: Byte-wide registers reached by an 8-bit register address.
// Notes:   Offsets are register addresses on the serial register port.
package hvpdo_pkg;

    // ========================================================================
    // Sizes
    // ========================================================================
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned PINS     = 8;
    localparam int unsigned OL_PINS  = 4;
    localparam int unsigned SEL_W    = 2;

    // ========================================================================
    // Register offsets
    // ========================================================================
    localparam logic [7:0] OFS_OL_THRESHOLD = 8'h4A;
    localparam logic [7:0] OFS_HS_FORCE_OFF = 8'h71;
    localparam logic [7:0] OFS_LS_FORCE_OFF = 8'h72;

    // ========================================================================
    // Field positions of the open-load selectors
    // ========================================================================
    localparam int unsigned POS_PIN5_OL = 0;
    localparam int unsigned POS_PIN6_OL = 2;
    localparam int unsigned POS_PIN7_OL = 4;
    localparam int unsigned POS_PIN8_OL = 6;

    // ========================================================================
    // Values after reset
    // ========================================================================
    localparam logic [7:0] RST_OL_THRESHOLD = 8'h00;
    localparam logic [7:0] RST_FORCE_OFF    = 8'h00;
    localparam logic [7:0] RD_UNMAPPED      = 8'h00;

    // ========================================================================
    // Open-load detection conditions
    // ========================================================================
    typedef enum logic [1:0] {
        OL_COND_00 = 2'h0,
        OL_COND_01 = 2'h1,
        OL_COND_10 = 2'h2,
        OL_COND_11 = 2'h3
    } hvpdo_ol_cond_e;

endpackage

/* File: verilog/hvpdo_drive_if.sv */
// Purpose: Carries per-pin driver requests, force-off bits and enables.
// Assumes: One bit per pin, bit n-1 serves pin n.
// Notes:   The core fills requests and force bits, the gate returns enables.
`timescale 1ns/1ps
interface hvpdo_drive_if #(
    parameter int unsigned PINS = 8
);
    logic [PINS-1:0] hs_req;
    logic [PINS-1:0] ls_req;
    logic [PINS-1:0] hs_force;
    logic [PINS-1:0] ls_force;
    logic [PINS-1:0] hs_en;
    logic [PINS-1:0] ls_en;

    modport core (
        output hs_req,
        output ls_req,
        output hs_force,
        output ls_force,
        input  hs_en,
        input  ls_en
    );

    modport gate (
        input  hs_req,
        input  ls_req,
        input  hs_force,
        input  ls_force,
        output hs_en,
        output ls_en
    );
endinterface

/* File: verilog/hvpdo_gate.sv */
// Purpose: Gates each pin's driver enables with its force-off bits.
// Assumes: Requests and force bits are on the same clock as the core.
// Notes:   Purely combinational, so a forced-off driver drops at once.
`timescale 1ns/1ps
module hvpdo_gate (
    hvpdo_drive_if.gate drv
);
    // A set force bit wins over any request; a clear one passes it through.
    assign drv.hs_en = drv.hs_req & ~drv.hs_force;
    assign drv.ls_en = drv.ls_req & ~drv.ls_force;
endmodule

/* File: verilog/hvpdo_regs.sv */
// Purpose: Override and open-load threshold register bank for the
//          high-voltage pins, with driver enable gating.
// Assumes: The serial frame decoder presents one byte access per cycle on
//          the register port; driver requests come from the pin control
//          registers on the same clock.
// Notes:   Force-off registers mirror a non-volatile store: the stored image
//          is loaded once after reset and writes need the unlock level.
//
// How it works
// - Register 4Ah holds the two-bit open-load selectors of pins 8 to 5.
// - Each selector picks one of four open-load conditions for its pin.
// - High-side force bit 0, the preset, passes the pin's own request.
// - High-side force bit 1 keeps that pin's high-side switch off.
// - Low-side force bit 0, the preset, passes the pin's own request.
// - Low-side force bit 1 keeps that pin's low-side switch off.
// - Registers 71h and 72h map pin n to bit n-1.
// - Force registers are non-volatile: loaded from the stored image after reset, then changed only by writes under write unlock.
`timescale 1ns/1ps
module hvpdo_regs #(
    parameter int unsigned PINS = 8
) (
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      ce_in,
    input  wire logic                      wr_en_in,
    input  wire logic                      rd_en_in,
    input  wire logic [7:0]                addr_in,
    input  wire logic [7:0]                wr_data_in,
    input  wire logic                      nv_unlock_in,
    input  wire logic [PINS-1:0]           nv_hs_image_in,
    input  wire logic [PINS-1:0]           nv_ls_image_in,
    input  wire logic [PINS-1:0]           hs_req_in,
    input  wire logic [PINS-1:0]           ls_req_in,
    output logic      [7:0]                rd_data_out,
    output logic                           rd_valid_out,
    output logic                           wr_refused_out,
    output logic                           nv_prog_out,
    output logic                           ready_out,
    output logic      [1:0]                pin5_open_load_sel_out,
    output logic      [1:0]                pin6_open_load_sel_out,
    output logic      [1:0]                pin7_open_load_sel_out,
    output logic      [1:0]                pin8_open_load_sel_out,
    output logic      [PINS-1:0]           hs_en_out,
    output logic      [PINS-1:0]           ls_en_out
);

    // ========================================================================
    // Storage
    // ========================================================================
    logic [7:0]      ol_threshold;
    logic [PINS-1:0] high_side_force_off;
    logic [PINS-1:0] low_side_force_off;
    logic            loaded;
    logic            hit_thr;
    logic            hit_hs;
    logic            hit_ls;
    logic            wr_ok;
    logic            wr_nv_ok;

    hvpdo_drive_if #(.PINS(PINS)) drv ();

    assign hit_thr  = addr_in == hvpdo_pkg::OFS_OL_THRESHOLD;
    assign hit_hs   = addr_in == hvpdo_pkg::OFS_HS_FORCE_OFF;
    assign hit_ls   = addr_in == hvpdo_pkg::OFS_LS_FORCE_OFF;
    assign wr_ok    = ce_in && wr_en_in && loaded;
    assign wr_nv_ok = wr_ok && nv_unlock_in && (hit_hs || hit_ls);

    // ========================================================================
    // Non-volatile image load
    // ========================================================================
    // The stored image arrives after reset; until then writes are dropped
    // so that a load cannot overwrite a host write.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            loaded <= 1'b0;
        end else if (ce_in) begin
            loaded <= 1'b1;
        end
    end

    // ========================================================================
    // Open-load threshold register
    // ========================================================================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ol_threshold <= hvpdo_pkg::RST_OL_THRESHOLD;
        end else if (wr_ok && hit_thr) begin
            ol_threshold <= wr_data_in;
        end
    end

    // Each pin's detector sees its own two-bit condition code.
    assign pin5_open_load_sel_out =
        ol_threshold[hvpdo_pkg::POS_PIN5_OL +: 2];
    assign pin6_open_load_sel_out =
        ol_threshold[hvpdo_pkg::POS_PIN6_OL +: 2];
    assign pin7_open_load_sel_out =
        ol_threshold[hvpdo_pkg::POS_PIN7_OL +: 2];
    assign pin8_open_load_sel_out =
        ol_threshold[hvpdo_pkg::POS_PIN8_OL +: 2];

    // ========================================================================
    // Force-off registers
    // ========================================================================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            high_side_force_off <= PINS'(hvpdo_pkg::RST_FORCE_OFF);
        end else if (ce_in && !loaded) begin
            high_side_force_off <= nv_hs_image_in;
        end else if (wr_nv_ok && hit_hs) begin
            high_side_force_off <= wr_data_in[PINS-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_side_force_off <= PINS'(hvpdo_pkg::RST_FORCE_OFF);
        end else if (ce_in && !loaded) begin
            low_side_force_off <= nv_ls_image_in;
        end else if (wr_nv_ok && hit_ls) begin
            low_side_force_off <= wr_data_in[PINS-1:0];
        end
    end

    // A write that reaches the store asks the memory to program it; one
    // that lacks the unlock is reported and leaves the contents alone.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nv_prog_out    <= 1'b0;
            wr_refused_out <= 1'b0;
        end else if (ce_in) begin
            nv_prog_out    <= wr_nv_ok;
            wr_refused_out <= wr_ok && !nv_unlock_in
                              && (hit_hs || hit_ls);
        end
    end

    // ========================================================================
    // Read path
    // ========================================================================
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out  <= hvpdo_pkg::RD_UNMAPPED;
            rd_valid_out <= 1'b0;
        end else if (ce_in) begin
            rd_valid_out <= rd_en_in;
            if (rd_en_in) begin
                if (hit_thr) begin
                    rd_data_out <= ol_threshold;
                end else if (hit_hs) begin
                    rd_data_out <= 8'(high_side_force_off);
                end else if (hit_ls) begin
                    rd_data_out <= 8'(low_side_force_off);
                end else begin
                    rd_data_out <= hvpdo_pkg::RD_UNMAPPED;
                end
            end
        end
    end

    assign ready_out = loaded;

    // ========================================================================
    // Driver gating
    // ========================================================================
    assign drv.hs_req   = hs_req_in;
    assign drv.ls_req   = ls_req_in;
    assign drv.hs_force = high_side_force_off;
    assign drv.ls_force = low_side_force_off;

    hvpdo_gate u_gate (
        .drv (drv.gate)
    );

    assign hs_en_out = drv.hs_en;
    assign ls_en_out = drv.ls_en;

    // ========================================================================
    // Checks
    // ========================================================================
    sequence s_thr_write;
        wr_ok && hit_thr;
    endsequence

    sequence s_hs_locked_write;
        wr_ok && hit_hs && !nv_unlock_in;
    endsequence

    sequence s_hs_unlocked_write;
        wr_ok && hit_hs && nv_unlock_in;
    endsequence

    AST_THR_STORE: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        s_thr_write |=> ol_threshold == $past(wr_data_in)
    ) else $error("Threshold register did not take the write.");

    AST_THR_READ: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && rd_en_in && hit_thr
        |=> rd_valid_out && rd_data_out == $past(ol_threshold)
    ) else $error("Threshold read returned the wrong byte.");

    AST_OL_PIN_MAP: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        s_thr_write |=> pin8_open_load_sel_out == $past(wr_data_in[7:6])
                     && pin5_open_load_sel_out == $past(wr_data_in[1:0])
    ) else $error("Open-load selector reached the wrong pin.");

    AST_HS_PASS: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (hs_en_out & ~high_side_force_off)
            == (hs_req_in & ~high_side_force_off)
    ) else $error("High-side request not passed through.");

    AST_HS_OFF: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (hs_en_out & high_side_force_off) == '0
    ) else $error("Forced-off high-side driver is on.");

    AST_LS_PASS: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (ls_en_out & ~low_side_force_off)
            == (ls_req_in & ~low_side_force_off)
    ) else $error("Low-side request not passed through.");

    AST_LS_OFF: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (ls_en_out & low_side_force_off) == '0
    ) else $error("Forced-off low-side driver is on.");

    AST_HS_BIT_MAP: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        s_hs_unlocked_write ##1 hs_req_in[PINS-1]
        |-> hs_en_out[PINS-1] == !$past(wr_data_in[PINS-1])
    ) else $error("Pin 8 high-side force bit is not bit 7.");

    AST_NV_LOCKED: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        s_hs_locked_write |=> $stable(high_side_force_off) && wr_refused_out
                              && !nv_prog_out
    ) else $error("Locked write changed the non-volatile store.");

    AST_NO_DELAY: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(low_side_force_off[0]) |-> !ls_en_out[0]
    ) else $error("Forced-off driver did not drop in the same cycle.");

endmodule

/* File: verification/hvpdo_host_model.sv */
// Purpose: Host model that makes byte accesses on the register port.
// Assumes: Requests change at the falling clock edge.
// Notes:   One access per call; a read returns what the next edge shows.
`timescale 1ns/1ps
module hvpdo_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rd_data_in,
    input  wire logic       rd_valid_in,
    output logic            ce_out,
    output logic            wr_en_out,
    output logic            rd_en_out,
    output logic [7:0]      addr_out,
    output logic [7:0]      wr_data_out,
    output logic            nv_unlock_out
);
    initial begin
        ce_out        = 1'b1;
        wr_en_out     = 1'b0;
        rd_en_out     = 1'b0;
        addr_out      = 8'h00;
        wr_data_out   = 8'h00;
        nv_unlock_out = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic u);
        @(negedge clk_in);
        addr_out      = a;
        wr_data_out   = d;
        nv_unlock_out = u;
        wr_en_out     = 1'b1;
        @(negedge clk_in);
        wr_en_out     = 1'b0;
        wr_data_out   = ~d;
        nv_unlock_out = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(negedge clk_in);
        addr_out  = a;
        rd_en_out = 1'b1;
        @(negedge clk_in);
        rd_en_out = 1'b0;
        d         = rd_data_in;
        v         = rd_valid_in;
    endtask
endmodule

/* File: verification/hvpdo_regs_bench.sv */
// Purpose: Self-checking bench for the driver override register bank.
// Assumes: Inputs change at the falling edge of a 4 ns clock.
// Notes:   Reset check first, then table rows, gating, clock enable and a second reset.
`timescale 1ns/1ps
module hvpdo_regs_bench;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic       u;
        logic [7:0] rb;
        logic       prog;
        logic       refu;
    } hvpdo_row_s;

    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       ce, wr_en, rd_en, unlock, rd_valid, wr_refused, nv_prog;
    logic       ready;
    logic [7:0] addr, wr_data, rd_data, hs_en, ls_en;
    logic [7:0] hs_img = 8'h81;
    logic [7:0] ls_img = 8'h42;
    logic [7:0] hs_req = 8'hFF;
    logic [7:0] ls_req = 8'hFF;
    logic [1:0] sel5, sel6, sel7, sel8;
    int         err_count = 0;
    int         comparisons = 0;
    hvpdo_row_s rows [9] = '{
        '{8'h4A, 8'hE4, 1'b0, 8'hE4, 1'b0, 1'b0},
        '{8'h4A, 8'h1B, 1'b0, 8'h1B, 1'b0, 1'b0},
        '{8'h71, 8'h80, 1'b1, 8'h80, 1'b1, 1'b0},
        '{8'h71, 8'h01, 1'b0, 8'h80, 1'b0, 1'b1},
        '{8'h72, 8'h01, 1'b1, 8'h01, 1'b1, 1'b0},
        '{8'h72, 8'hFF, 1'b0, 8'h01, 1'b0, 1'b1},
        '{8'h33, 8'hFF, 1'b1, 8'h00, 1'b0, 1'b0},
        '{8'h71, 8'h00, 1'b1, 8'h00, 1'b1, 1'b0},
        '{8'h72, 8'h00, 1'b1, 8'h00, 1'b1, 1'b0}};
    logic [7:0] reqs [4] = '{8'hFF, 8'h0F, 8'h01, 8'h80};

    always #2 clk_in = ~clk_in;

    hvpdo_host_model i_hvpdo_host_model (
        .clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
        .ce_out(ce), .wr_en_out(wr_en), .rd_en_out(rd_en),
        .addr_out(addr), .wr_data_out(wr_data), .nv_unlock_out(unlock));

    hvpdo_regs i_hvpdo_regs (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
        .wr_data_in(wr_data), .nv_unlock_in(unlock),
        .nv_hs_image_in(hs_img), .nv_ls_image_in(ls_img),
        .hs_req_in(hs_req), .ls_req_in(ls_req), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .wr_refused_out(wr_refused),
        .nv_prog_out(nv_prog), .ready_out(ready),
        .pin5_open_load_sel_out(sel5), .pin6_open_load_sel_out(sel6),
        .pin7_open_load_sel_out(sel7), .pin8_open_load_sel_out(sel8),
        .hs_en_out(hs_en), .ls_en_out(ls_en));

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_hvpdo_host_model.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask

    task automatic check_reset(input logic [7:0] hi, input logic [7:0] li);
        hs_img = hi;
        ls_img = li;
        hs_req = 8'hFF;
        ls_req = 8'hFF;
        @(negedge clk_in);
        rst_n_in = 1'b0;
        #1;
        chk(hs_en, 8'hFF);
        chk(ls_en, 8'hFF);
        chk({7'h00, ready}, 8'h00);
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk({7'h00, ready}, 8'h01);
        chk(hs_en, ~hi);
        chk(ls_en, ~li);
        rd_chk(hvpdo_pkg::OFS_OL_THRESHOLD,
               hvpdo_pkg::RST_OL_THRESHOLD);
        rd_chk(hvpdo_pkg::OFS_HS_FORCE_OFF, hi);
        rd_chk(hvpdo_pkg::OFS_LS_FORCE_OFF, li);
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ========================================================================
    // Sequence
    // ========================================================================
    initial begin
        check_reset(8'h81, 8'h42);
        foreach (rows[i]) begin
            i_hvpdo_host_model.wr(rows[i].a, rows[i].d, rows[i].u);
            chk({7'h00, nv_prog}, {7'h00, rows[i].prog});
            chk({7'h00, wr_refused}, {7'h00, rows[i].refu});
            if (rows[i].a == hvpdo_pkg::OFS_OL_THRESHOLD) begin
                chk({sel8, sel7, sel6, sel5}, rows[i].d);
            end
            rd_chk(rows[i].a, rows[i].rb);
        end
        i_hvpdo_host_model.wr(hvpdo_pkg::OFS_HS_FORCE_OFF, 8'hA5, 1'b1);
        i_hvpdo_host_model.wr(hvpdo_pkg::OFS_LS_FORCE_OFF, 8'h3C, 1'b1);
        foreach (reqs[i]) begin
            @(negedge clk_in);
            hs_req = reqs[i];
            ls_req = ~reqs[i];
            #1;
            chk(hs_en, reqs[i] & 8'h5A);
            chk(ls_en, ~reqs[i] & 8'hC3);
        end
        i_hvpdo_host_model.ce_out = 1'b0;
        i_hvpdo_host_model.wr(hvpdo_pkg::OFS_HS_FORCE_OFF, 8'hFF, 1'b1);
        chk({7'h00, nv_prog}, 8'h00);
        i_hvpdo_host_model.ce_out = 1'b1;
        rd_chk(hvpdo_pkg::OFS_HS_FORCE_OFF, 8'hA5);
        check_reset(8'h00, 8'hFF);
        wrap_up();
    end

    initial begin
        #20000;
        err_count++;
        wrap_up();
    end
endmodule
